// *** common/mlc_bus_if.sv ***
`timescale 1ns/1ns
interface mlc_bus_if;
    logic strobe;
    mlc_pkg::mlc_op_t op;
    logic [3:0] func;
    logic [5:0] dev;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic ready;
    logic skip;
    logic irq;
    modport dev_mp (input strobe, input op, input func, input dev,
        input wdata, output rdata, output ready, output skip, output irq);
    modport host_mp (output strobe, output op, output func, output dev,
        output wdata, input rdata, input ready, input skip, input irq);
endinterface : mlc_bus_if

// *** common/mlc_pkg.sv ***
package mlc_pkg;
    // instruction classes on the i/o bus
    typedef enum logic [1:0] {
        MLC_CP  = 2'b00,
        MLC_SKS = 2'b01,
        MLC_INA = 2'b10,
        MLC_OTA = 2'b11
    } mlc_op_t;
    localparam int NLINES = 16;
    localparam logic [5:0] DEV_ADDR_DEF = 6'h15; // arbitrary value
    // control pulse functions
    localparam logic [3:0] FN_STOP_CLK = 4'h0;
    localparam logic [3:0] FN_STEP_CLK = 4'h1;
    localparam logic [3:0] FN_NORMAL = 4'ha;
    localparam logic [3:0] FN_DIAG = 4'hb;
    localparam logic [3:0] FN_SET_MASK = 4'hd;
    localparam logic [3:0] FN_CLR_MASK = 4'he;
    localparam logic [3:0] FN_INIT = 4'hf;
    // skip test
    localparam logic [3:0] FN_NOT_INTR = 4'h4;
    // input functions
    localparam logic [3:0] FN_IN_MODEM = 4'h0;
    localparam logic [3:0] FN_IN_STATUS = 4'h7;
    localparam logic [3:0] FN_IN_ID = 4'h9;
    // output functions
    localparam logic [3:0] FN_OUT_LINE_SEL = 4'h0;
    localparam logic [3:0] FN_OUT_CONFIG = 4'h1;
    localparam logic [3:0] FN_OUT_CONTROL = 4'h2;
    localparam logic [3:0] FN_OUT_MODEM = 4'h3;
    localparam logic [3:0] FN_OUT_USER_CLK = 4'hf;
    // config word fields (bit 0 = word bit 16)
    localparam int CFG_LINE_LSB = 12;
    localparam int CFG_SIZE_LSB = 0;
    localparam int CFG_STOP_BIT = 2;
    localparam int CFG_PAR_EN_BIT = 3;
    localparam int CFG_PAR_ODD_BIT = 4;
    localparam int CFG_SPEED_LSB = 5;
    localparam int CFG_MODEM_BIT = 8;
    localparam int CFG_ECHO_BIT = 9;
    // modem control word bits: 16 rts, 15 dtr, 14 originate
    localparam int MC_RTS_BIT = 0;
    localparam int MC_DTR_BIT = 1;
    localparam int MC_ORIG_BIT = 2;
    // status word bit positions
    localparam int ST_DIAG_BIT = 15;
    localparam int ST_MASK_BIT = 14;
    localparam int ST_RUN_BIT = 4;
    localparam int ST_INTR_BIT = 0;
    // busy time
    localparam int CLK_MHZ = 250;
    localparam int BUSY_US = 20;
    localparam int BUSY_CYC = BUSY_US * CLK_MHZ;
    // fixed rate table, baud * 10 (index 0..7 except 4, which is SPEED_USER)
    localparam int RATE_X10_0 = 1100;
    localparam int RATE_X10_1 = 1345;
    localparam int RATE_X10_2 = 3000;
    localparam int RATE_X10_3 = 12000;
    localparam int RATE_X10_5 = 750;
    localparam int RATE_X10_6 = 1500;
    localparam int RATE_X10_7 = 18000;
    localparam logic [2:0] SPEED_USER = 3'h4;
endpackage : mlc_pkg

// *** dv/mlc_bus_monitor.sv ***
`timescale 1ns/1ns
module mlc_bus_monitor #(
    parameter logic [5:0] DEV_ADDR = mlc_pkg::DEV_ADDR_DEF
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic strobe,
    input wire mlc_pkg::mlc_op_t op,
    input wire logic [3:0] func,
    input wire logic [5:0] dev,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic ready,
    input wire logic skip,
    input wire logic irq
);
    logic diag_r;
    logic mask_r;
    logic run_r;
    logic hit;
    logic cp;
    logic xfer;
    // mode shadow built only from what crosses the bus
    assign hit = strobe && dev == DEV_ADDR && ready;
    assign cp = hit && op == mlc_pkg::MLC_CP;
    assign xfer = skip && (op == mlc_pkg::MLC_OTA ||
        (op == mlc_pkg::MLC_INA && func != mlc_pkg::FN_IN_STATUS));
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            diag_r <= 1'b0;
            mask_r <= 1'b0;
            run_r <= 1'b1;
        end else if (cp) begin
            case (func)
                mlc_pkg::FN_DIAG: diag_r <= 1'b1;
                mlc_pkg::FN_NORMAL: diag_r <= 1'b0;
                mlc_pkg::FN_SET_MASK: mask_r <= 1'b1;
                mlc_pkg::FN_CLR_MASK: mask_r <= 1'b0;
                mlc_pkg::FN_STOP_CLK: run_r <= run_r && !diag_r;
                mlc_pkg::FN_INIT: begin
                    diag_r <= 1'b0;
                    mask_r <= 1'b0;
                    run_r <= 1'b1;
                end
                default: ;
            endcase
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence ota_take;
        strobe && skip && op == mlc_pkg::MLC_OTA;
    endsequence
    sequence stat_take;
        strobe && skip && op == mlc_pkg::MLC_INA &&
            func == mlc_pkg::FN_IN_STATUS;
    endsequence
    // one clearing scan: exactly one not-ready cycle per line, sixteen
    sequence scan_run;
        !ready[*8] ##1 !ready[*8] ##1 ready;
    endsequence
    addr_only_a: assert property (
        skip |-> strobe && dev == DEV_ADDR)
        else $error("skip without own address");
    reset_scan_a: assert property ($rose(resetn_i) |-> scan_run)
        else $error("clearing scan after reset wrong");
    init_scan_a: assert property (
        cp && func == mlc_pkg::FN_INIT |=> scan_run)
        else $error("clearing scan after init wrong");
    scan_noskip_a: assert property (!ready |-> !skip)
        else $error("skip during clearing scan");
    status_skip_a: assert property (
        hit && op == mlc_pkg::MLC_INA &&
        func == mlc_pkg::FN_IN_STATUS |-> skip)
        else $error("status input did not skip");
    busy_hold_a: assert property (ota_take |=> !xfer[*7])
        else $error("transfer accepted while busy");
    intr_skip_a: assert property (hit && op == mlc_pkg::MLC_SKS &&
        func == mlc_pkg::FN_NOT_INTR |-> skip == !irq)
        else $error("skip test disagrees with irq");
    stat_mode_a: assert property (stat_take |=>
        rdata[mlc_pkg::ST_DIAG_BIT] == diag_r &&
        rdata[mlc_pkg::ST_RUN_BIT] == run_r)
        else $error("status mode bits wrong");
    stat_mask_a: assert property (
        stat_take |=> rdata[mlc_pkg::ST_MASK_BIT] == mask_r)
        else $error("status mask bit wrong");
    irq_gate_a: assert property (irq |-> mask_r)
        else $error("irq with mask clear");
endmodule : mlc_bus_monitor

// *** dv/test_multiline_async_host_control.sv ***
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
    begin \
        tests_run++; \
        if ((got) !== (ex)) begin \
            errors++; \
            $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
        end \
    end
module test_multiline_async_host_control;
    localparam int BUSY = 8;
    localparam logic [15:0] ID = 16'h0031; // arbitrary value
    logic clk_i, resetn_i, req_i, req_ready, done, done_skip, irq;
    mlc_pkg::mlc_op_t req_op;
    logic [3:0] req_func;
    logic [15:0] req_wdata, done_rdata, modem_st, tx_data, rd;
    logic pend, tx_ready, tx_valid, clk_en, sk;
    logic [3:0] modem_ctl [mlc_pkg::NLINES];
    logic [15:0] line_cfg [mlc_pkg::NLINES];
    logic [15:0] line_ctl [mlc_pkg::NLINES];
    logic [11:0] preset;
    int errors, tests_run, cyc, en_cnt, pops, n, t1;
    mlc_bus_if bus_if();
    mlc_dev #(.BUSY_CYCLES(BUSY), .ID_CODE(ID)) u_mlc_dev (.clk_i(clk_i),
        .resetn_i(resetn_i), .bus(bus_if), .modem_status_i(modem_st),
        .pend_intr_i(pend), .modem_ctl_o(modem_ctl), .line_cfg_o(line_cfg),
        .line_ctl_o(line_ctl), .user_preset_o(preset),
        .sys_clk_en_o(clk_en), .tx_valid_o(tx_valid),
        .tx_ready_i(tx_ready), .tx_data_o(tx_data));
    mlc_host u_mlc_host (.clk_i(clk_i), .resetn_i(resetn_i), .bus(bus_if),
        .req_i(req_i), .req_op_i(req_op), .req_func_i(req_func),
        .req_wdata_i(req_wdata), .req_ready_o(req_ready), .done_o(done),
        .done_skip_o(done_skip), .done_rdata_o(done_rdata), .irq_o(irq));
    mlc_bus_monitor u_mlc_bus_monitor (.clk_i(clk_i), .resetn_i(resetn_i),
        .strobe(bus_if.strobe), .op(bus_if.op), .func(bus_if.func),
        .dev(bus_if.dev), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
        .ready(bus_if.ready), .skip(bus_if.skip), .irq(bus_if.irq));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // ceiling well above the few hundred cycles the run needs
    always @(posedge clk_i) begin
        cyc++;
        if (clk_en === 1'b1) en_cnt++;
        if (tx_valid === 1'b1 && tx_ready === 1'b1) pops++;
        if (cyc == 20000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    task automatic wait_done();
        n = 0;
        while (done !== 1'b1 && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 400) `CHK("done seen", 1'b1, 1'b0)
    endtask : wait_done
    task automatic issue(input mlc_pkg::mlc_op_t op, input logic [3:0] fn,
        input logic [15:0] wd);
        req_op = op;
        req_func = fn;
        req_wdata = wd;
        req_i = 1'b1;
        @(negedge clk_i);
        req_i = 1'b0;
        wait_done();
        sk = done_skip;
        rd = done_rdata;
    endtask : issue
    task automatic cp(input logic [3:0] fn);
        issue(mlc_pkg::MLC_CP, fn, 16'h0000);
    endtask : cp
    task automatic status();
        issue(mlc_pkg::MLC_INA, mlc_pkg::FN_IN_STATUS, 16'h0000);
    endtask : status
    task automatic t_scan();
        n = 0;
        while (bus_if.ready !== 1'b1 && n < 100) begin
            @(negedge clk_i);
            n++;
        end
        `CHK("scan length", mlc_pkg::NLINES, n)
        for (int i = 0; i < mlc_pkg::NLINES; i++)
            `CHK("line ctl", 16'h0000, line_ctl[i])
    endtask : t_scan
    task automatic t_modes();
        cp(mlc_pkg::FN_NORMAL);
        cp(mlc_pkg::FN_STOP_CLK);
        status();
        `CHK("normal diag", 1'b0, rd[mlc_pkg::ST_DIAG_BIT])
        `CHK("normal run", 1'b1, rd[mlc_pkg::ST_RUN_BIT])
        cp(mlc_pkg::FN_DIAG);
        cp(mlc_pkg::FN_STOP_CLK);
        status();
        `CHK("diag set", 1'b1, rd[mlc_pkg::ST_DIAG_BIT])
        `CHK("diag stop", 1'b0, rd[mlc_pkg::ST_RUN_BIT])
        en_cnt = 0;
        cp(mlc_pkg::FN_STEP_CLK);
        repeat (4) @(negedge clk_i);
        `CHK("step pulses", 1, en_cnt)
        // a control word that the initialize scan has to wipe
        issue(mlc_pkg::MLC_OTA, mlc_pkg::FN_OUT_CONTROL, 16'h2001);
        `CHK("ctl before init", 16'h2001, line_ctl[2])
        cp(mlc_pkg::FN_INIT);
        t_scan();
        status();
        `CHK("init diag", 1'b0, rd[mlc_pkg::ST_DIAG_BIT])
        `CHK("init run", 1'b1, rd[mlc_pkg::ST_RUN_BIT])
        // a pulse issued inside the scan must wait for it to end
        cp(mlc_pkg::FN_INIT);
        t1 = cyc;
        cp(mlc_pkg::FN_SET_MASK);
        `CHK("held in scan", 1'b1, cyc - t1 > mlc_pkg::NLINES)
    endtask : t_modes
    task automatic t_mask();
        pend = 1'b1;
        cp(mlc_pkg::FN_CLR_MASK);
        `CHK("irq masked", 1'b0, irq)
        issue(mlc_pkg::MLC_SKS, mlc_pkg::FN_NOT_INTR, 16'h0000);
        `CHK("skip quiet", 1'b1, sk)
        cp(mlc_pkg::FN_SET_MASK);
        `CHK("irq open", 1'b1, irq)
        issue(mlc_pkg::MLC_SKS, mlc_pkg::FN_NOT_INTR, 16'h0000);
        `CHK("skip busy irq", 1'b0, sk)
        status();
        `CHK("mask bit", 1'b1, rd[mlc_pkg::ST_MASK_BIT])
        `CHK("irq bit", 1'b1, rd[mlc_pkg::ST_INTR_BIT])
        cp(mlc_pkg::FN_CLR_MASK);
        pend = 1'b0;
    endtask : t_mask
    task automatic t_lines();
        issue(mlc_pkg::MLC_OTA, mlc_pkg::FN_OUT_CONFIG, 16'h53ad);
        `CHK("line cfg", 10'h3ad, line_cfg[5][9:0])
        issue(mlc_pkg::MLC_OTA, mlc_pkg::FN_OUT_MODEM, 16'h3005);
        `CHK("modem ctl", 4'h5, modem_ctl[3])
        // line 2 has echo off, so its interrupts may be enabled
        issue(mlc_pkg::MLC_OTA, mlc_pkg::FN_OUT_CONTROL, 16'h2001);
        `CHK("line ctl", 2'h1, line_ctl[2][1:0])
        issue(mlc_pkg::MLC_OTA, mlc_pkg::FN_OUT_USER_CLK, 16'h05a3);
        `CHK("user preset", 12'h5a3, preset)
        // both low control bits set must never reach the bus
        req_op = mlc_pkg::MLC_OTA;
        req_func = mlc_pkg::FN_OUT_CONTROL;
        req_wdata = 16'h0003;
        @(negedge clk_i);
        `CHK("both bits refused", 1'b0, req_ready)
    endtask : t_lines
    task automatic t_busy();
        modem_st = 16'h0020;
        issue(mlc_pkg::MLC_OTA, mlc_pkg::FN_OUT_LINE_SEL, 16'h0005);
        t1 = cyc;
        issue(mlc_pkg::MLC_INA, mlc_pkg::FN_IN_MODEM, 16'h0000);
        `CHK("busy wait", 1'b1, cyc - t1 >= BUSY)
        `CHK("modem line 5", 1'b1, rd[0])
        issue(mlc_pkg::MLC_OTA, mlc_pkg::FN_OUT_LINE_SEL, 16'h0004);
        t1 = cyc;
        status();
        `CHK("status fast", 1'b1, cyc - t1 <= 4)
        `CHK("status skip", 1'b1, sk)
        issue(mlc_pkg::MLC_INA, mlc_pkg::FN_IN_MODEM, 16'h0000);
        `CHK("modem line 4", 1'b0, rd[0])
        issue(mlc_pkg::MLC_INA, mlc_pkg::FN_IN_ID, 16'h0000);
        `CHK("id code", ID, rd)
    endtask : t_busy
    task automatic t_fifo();
        tx_ready = 1'b0;
        repeat (16)
            issue(mlc_pkg::MLC_OTA, mlc_pkg::FN_OUT_LINE_SEL, 16'h0001);
        req_i = 1'b1;
        @(negedge clk_i);
        req_i = 1'b0;
        n = 0;
        repeat (40) begin
            @(negedge clk_i);
            if (done === 1'b1) n++;
        end
        `CHK("full refused", 0, n)
        pops = 0;
        tx_ready = 1'b1;
        wait_done();
        repeat (30) @(negedge clk_i);
        `CHK("words drained", 17, pops)
    endtask : t_fifo
    initial begin
        resetn_i = 1'b0;
        req_i = 1'b0;
        req_op = mlc_pkg::MLC_CP;
        req_func = 4'h0;
        req_wdata = 16'h0000;
        modem_st = 16'h0000;
        pend = 1'b0;
        tx_ready = 1'b1;
        repeat (5) @(negedge clk_i);
        resetn_i = 1'b1;
        t_scan();
        t_modes();
        t_mask();
        t_lines();
        t_busy();
        t_fifo();
        end_of_test();
    end
endmodule : test_multiline_async_host_control

// *** rtl/mlc_dev.sv ***
`timescale 1ns/1ns
module mlc_dev #(
    parameter logic [5:0] DEV_ADDR = mlc_pkg::DEV_ADDR_DEF,
    parameter logic [15:0] ID_CODE = 16'h002a, // arbitrary value
    parameter bit FULL_MODEM = 1'b1,
    parameter int BUSY_CYCLES = mlc_pkg::BUSY_CYC,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    mlc_bus_if.dev_mp bus,
    input wire logic [15:0] modem_status_i,
    input wire logic pend_intr_i,
    output logic [3:0] modem_ctl_o [mlc_pkg::NLINES],
    output logic [15:0] line_cfg_o [mlc_pkg::NLINES],
    output logic [15:0] line_ctl_o [mlc_pkg::NLINES],
    output logic [11:0] user_preset_o,
    output logic sys_clk_en_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    output logic [15:0] tx_data_o
);
    logic diag_r, diag_nxt, run_r, run_nxt, step_r, step_nxt;
    logic mask_r, mask_nxt;
    logic [4:0] scan_r, scan_nxt;
    logic [13:0] busy_r, busy_nxt;
    logic [3:0] sel_r, sel_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic [11:0] pre_r, pre_nxt;
    logic [15:0] cfg_r [mlc_pkg::NLINES];
    logic [15:0] ctl_r [mlc_pkg::NLINES];
    logic [3:0] mc_r [mlc_pkg::NLINES];
    logic hit, clearing, busy, irq, fifo_in_rdy;
    logic [3:0] wl;

    assign hit = bus.strobe && bus.dev == DEV_ADDR;
    assign clearing = !scan_r[4];
    assign busy = busy_r != '0;
    assign irq = pend_intr_i && mask_r && run_r;
    assign wl = bus.wdata[mlc_pkg::CFG_LINE_LSB +: 4];
    assign bus.irq = irq;
    assign bus.rdata = rdata_r;
    assign bus.ready = !clearing;
    always_comb begin
        bus.skip = 1'b0;
        if (hit && !clearing) begin
            unique case (bus.op)
                mlc_pkg::MLC_SKS: bus.skip =
                    bus.func == mlc_pkg::FN_NOT_INTR && !irq;
                mlc_pkg::MLC_INA: bus.skip =
                    bus.func == mlc_pkg::FN_IN_STATUS || !busy;
                mlc_pkg::MLC_OTA: bus.skip = !busy && fifo_in_rdy;
                mlc_pkg::MLC_CP: bus.skip = 1'b0;
            endcase
        end
    end
    assign sys_clk_en_o = run_r || step_r;
    assign user_preset_o = pre_r;
    always_comb begin
        for (int i = 0; i < mlc_pkg::NLINES; i++) begin
            modem_ctl_o[i] = mc_r[i];
            line_cfg_o[i] = cfg_r[i];
            line_ctl_o[i] = ctl_r[i];
        end
    end

    always_comb begin
        diag_nxt = diag_r;
        run_nxt = run_r;
        step_nxt = 1'b0;
        mask_nxt = mask_r;
        scan_nxt = clearing ? scan_r + 5'h01 : scan_r;
        busy_nxt = busy ? busy_r - 14'h0001 : busy_r;
        sel_nxt = sel_r;
        rdata_nxt = rdata_r;
        pre_nxt = pre_r;
        // pulses wait out the clearing scan like every other instruction
        if (hit && !clearing && bus.op == mlc_pkg::MLC_CP) begin
            unique case (bus.func)
                mlc_pkg::FN_STOP_CLK: if (diag_r) run_nxt = 1'b0;
                mlc_pkg::FN_STEP_CLK: step_nxt = diag_r;
                mlc_pkg::FN_NORMAL: diag_nxt = 1'b0;
                mlc_pkg::FN_DIAG: diag_nxt = 1'b1;
                mlc_pkg::FN_SET_MASK: mask_nxt = 1'b1;
                mlc_pkg::FN_CLR_MASK: mask_nxt = 1'b0;
                mlc_pkg::FN_INIT: begin
                    diag_nxt = 1'b0;
                    run_nxt = 1'b1;
                    mask_nxt = 1'b0;
                    scan_nxt = 5'h00;
                    busy_nxt = '0;
                    sel_nxt = '0;
                    rdata_nxt = '0;
                    pre_nxt = '0;
                end
                default: ;
            endcase
        end else if (bus.skip && bus.op == mlc_pkg::MLC_INA) begin
            unique case (bus.func)
                mlc_pkg::FN_IN_MODEM:
                    rdata_nxt = {15'h0000, modem_status_i[sel_r]};
                mlc_pkg::FN_IN_STATUS: begin
                    rdata_nxt = '0;
                    rdata_nxt[mlc_pkg::ST_DIAG_BIT] = diag_r;
                    rdata_nxt[mlc_pkg::ST_MASK_BIT] = mask_r;
                    rdata_nxt[mlc_pkg::ST_RUN_BIT] = run_r;
                    rdata_nxt[mlc_pkg::ST_INTR_BIT] = irq;
                end
                mlc_pkg::FN_IN_ID: rdata_nxt = ID_CODE;
                default: rdata_nxt = '0;
            endcase
        end else if (bus.skip && bus.op == mlc_pkg::MLC_OTA) begin
            // shared control logic stays busy after each output transfer
            busy_nxt = 14'(BUSY_CYCLES);
            unique case (bus.func)
                mlc_pkg::FN_OUT_LINE_SEL: sel_nxt = bus.wdata[3:0];
                mlc_pkg::FN_OUT_USER_CLK: pre_nxt = bus.wdata[11:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            diag_r <= 1'b0;
            run_r <= 1'b1;
            step_r <= 1'b0;
            mask_r <= 1'b0;
            scan_r <= 5'h00;
            busy_r <= '0;
            sel_r <= '0;
            rdata_r <= '0;
            pre_r <= '0;
        end else begin
            diag_r <= diag_nxt;
            run_r <= run_nxt;
            step_r <= step_nxt;
            mask_r <= mask_nxt;
            scan_r <= scan_nxt;
            busy_r <= busy_nxt;
            sel_r <= sel_nxt;
            rdata_r <= rdata_nxt;
            pre_r <= pre_nxt;
        end
    end

    // per-line tables; one line of the control table cleared per scan step
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < mlc_pkg::NLINES; i++) begin
                cfg_r[i] <= '0;
                ctl_r[i] <= '0;
                mc_r[i] <= '0;
            end
        end else if (clearing) begin
            ctl_r[scan_r[3:0]] <= '0;
        end else if (bus.skip && bus.op == mlc_pkg::MLC_OTA) begin
            unique case (bus.func)
                mlc_pkg::FN_OUT_CONFIG: begin
                    // line engines use size, stops, parity, speed, echo
                    cfg_r[wl] <= bus.wdata;
                    if (!FULL_MODEM) begin
                        mc_r[wl] <= {3'h0,
                            bus.wdata[mlc_pkg::CFG_MODEM_BIT]};
                    end
                end
                mlc_pkg::FN_OUT_CONTROL: ctl_r[wl] <= bus.wdata;
                mlc_pkg::FN_OUT_MODEM: if (FULL_MODEM) begin
                    mc_r[wl] <= {1'b0,
                        bus.wdata[mlc_pkg::MC_ORIG_BIT],
                        bus.wdata[mlc_pkg::MC_DTR_BIT],
                        bus.wdata[mlc_pkg::MC_RTS_BIT]};
                end
                default: ;
            endcase
        end
    end

    // accepted output words are queued for the line engines
    mlc_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .in_valid_i(bus.skip && bus.op == mlc_pkg::MLC_OTA),
        .in_ready_o(fifo_in_rdy),
        .in_data_i(bus.wdata),
        .out_valid_o(tx_valid_o),
        .out_ready_i(tx_ready_i),
        .out_data_o(tx_data_o)
    );
endmodule : mlc_dev

// *** rtl/mlc_fifo.sv ***
`timescale 1ns/1ns
module mlc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic push, pop;
    assign in_ready_o = (wp_r - rp_r) != (AW+1)'(DEPTH);
    assign out_valid_o = wp_r != rp_r;
    assign out_data_o = mem[rp_r[AW-1:0]];
    always_comb begin
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    end
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
    end
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wp_r[AW-1:0]] <= in_data_i;
        end
    end
endmodule : mlc_fifo

// *** rtl/mlc_host.sv ***
`timescale 1ns/1ns
module mlc_host #(
    parameter logic [5:0] DEV_ADDR = mlc_pkg::DEV_ADDR_DEF
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    mlc_bus_if.host_mp bus,
    input wire logic req_i,
    input wire mlc_pkg::mlc_op_t req_op_i,
    input wire logic [3:0] req_func_i,
    input wire logic [15:0] req_wdata_i,
    output logic req_ready_o,
    output logic done_o,
    output logic done_skip_o,
    output logic [15:0] done_rdata_o,
    output logic irq_o
);
    typedef enum logic [0:0] {
        HS_IDLE = 1'b0,
        HS_ISSUE = 1'b1
    } mlc_hst_t;
    mlc_hst_t st_r, st_nxt;
    mlc_pkg::mlc_op_t op_r, op_nxt;
    logic [3:0] fn_r, fn_nxt;
    logic [15:0] wd_r, wd_nxt;
    logic done_r, done_nxt, sk_r, sk_nxt;
    logic cfg_bad;

    // bits 15,16 of a control word are [1:0]
    assign cfg_bad = req_op_i == mlc_pkg::MLC_OTA &&
        req_func_i == mlc_pkg::FN_OUT_CONTROL && &req_wdata_i[1:0];
    assign req_ready_o = st_r == HS_IDLE && !cfg_bad;
    assign bus.strobe = st_r == HS_ISSUE;
    assign bus.op = op_r;
    assign bus.func = fn_r;
    assign bus.dev = DEV_ADDR;
    assign bus.wdata = wd_r;
    assign done_o = done_r;
    assign done_skip_o = sk_r;
    // read data lands in the device register on the accepting edge and
    // stands there until the next read or initialize pulse, so it is passed straight through
    assign done_rdata_o = bus.rdata;
    assign irq_o = bus.irq;

    always_comb begin
        st_nxt = st_r;
        op_nxt = op_r;
        fn_nxt = fn_r;
        wd_nxt = wd_r;
        done_nxt = 1'b0;
        sk_nxt = sk_r;
        unique case (st_r)
            HS_IDLE: if (req_i && req_ready_o) begin
                st_nxt = HS_ISSUE;
                op_nxt = req_op_i;
                fn_nxt = req_func_i;
                wd_nxt = req_wdata_i;
            end
            HS_ISSUE: begin
                // pulses and skip tests finish once ready; transfers retry
                if (bus.skip || (bus.ready &&
                        (bus.op == mlc_pkg::MLC_CP ||
                        bus.op == mlc_pkg::MLC_SKS))) begin
                    st_nxt = HS_IDLE;
                    done_nxt = 1'b1;
                    sk_nxt = bus.skip;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r <= HS_IDLE;
            op_r <= mlc_pkg::MLC_CP;
            fn_r <= '0;
            wd_r <= '0;
            done_r <= 1'b0;
            sk_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            op_r <= op_nxt;
            fn_r <= fn_nxt;
            wd_r <= wd_nxt;
            done_r <= done_nxt;
            sk_r <= sk_nxt;
        end
    end
endmodule : mlc_host
